/* src/ecpg_top.sv */
// Encoder counter, edge-separation timer and single-pulse generator with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "ecpg_consts.svh"

// Operation
// - Single-edge decode: up on A rise with B low, down on A fall with B low.
// - Double-edge decode counts on both A edges, direction from leading channel.
// - Quad-edge decode counts on every A and B edge, direction from leading channel.
// - Index high in the selected phase loads the reload value.
// - Software picks which of four A/B phases qualifies the index reload.
// - A count step and a reload together: step first, reload after.
// - Reload completes within one clock of the qualifying phase, then counting resumes.
// - Two-pulse mode counts up on each rising edge of A.
// - Two-pulse mode counts down on each rising edge of B.
// - Buffered position captures the count on each sample edge and sends it out.
// - Samples are cumulative since arming; sampling never clears the count.
// - Software selects rising or falling sample-clock edge.
// - Edge separation starts counting source edges at the first active aux edge.
// - Once counting, further aux edges are ignored.
// - Active gate edge stops counting and latches the count into save.
// - Single separation ignores all inputs after the latch.
// - Buffered separation restarts on next gate edge and sends each latched value.
// - Pulse starts after a programmed number of active source edges.
// - Pulse width is programmed in active source edges; the output is active high.
// - Triggered pulse starts its delay on a gate edge, then ignores the gate.
// - Retriggerable mode ignores gate edges during delay and pulse.
// - Retriggerable mode waits for a new trigger after each pulse.
module ecpg_top (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire ecpg_pkg::ecpg_pins_t pins,
  output ecpg_pkg::ecpg_dma_t    dma_out,
  input  wire logic              dma_ready,
  output logic                   pulse_out
);

  ecpg_pkg::ecpg_state_t st_ff;
  ecpg_pkg::ecpg_state_t nxt_st;

  // ----------------------------------------------------------------
  // Byte-lane merge for register writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decoded views of state
  // ----------------------------------------------------------------
  logic [5:0]           rise;
  logic [5:0]           fall;
  logic                 a_lvl;
  logic                 b_lvl;
  logic                 src_edge;
  logic                 aux_edge;
  logic                 gate_edge;
  ecpg_pkg::ecpg_mode_t mode;
  ecpg_pkg::ecpg_dec_t  dec;
  logic                 arm_bit;
  logic [31:0]          status;

  always_comb begin
    rise      = st_ff.sync2 & ~st_ff.prev;
    fall      = ~st_ff.sync2 & st_ff.prev;
    a_lvl     = st_ff.sync2[`ECPG_IN_A];
    b_lvl     = st_ff.sync2[`ECPG_IN_B];
    src_edge  = st_ff.ctrl[`ECPG_CTRL_SRC_FALL] ? fall[`ECPG_IN_SRC]
                                                : rise[`ECPG_IN_SRC];
    aux_edge  = st_ff.ctrl[`ECPG_CTRL_AUX_FALL] ? fall[`ECPG_IN_AUX]
                                                : rise[`ECPG_IN_AUX];
    gate_edge = st_ff.ctrl[`ECPG_CTRL_GATE_FALL] ? fall[`ECPG_IN_GATE]
                                                 : rise[`ECPG_IN_GATE];
    mode      = ecpg_pkg::ecpg_mode_t'(st_ff.ctrl[`ECPG_CTRL_MODE_HI:`ECPG_CTRL_MODE_LO]);
    dec       = ecpg_pkg::ecpg_dec_t'(st_ff.ctrl[`ECPG_CTRL_DEC_HI:`ECPG_CTRL_DEC_LO]);
    arm_bit   = st_ff.ctrl[`ECPG_CTRL_ARM];
    status    = `ECPG_RST_WORD;
    status[`ECPG_ST_ARMED]  = st_ff.armed;
    status[`ECPG_ST_PULSE]  = st_ff.pulse;
    status[`ECPG_ST_DONE]   = st_ff.done;
    status[`ECPG_ST_DVALID] = st_ff.dma.valid;
    status[`ECPG_ST_OVF]    = st_ff.ovf;
    status[`ECPG_ST_BUSY]   = (st_ff.run != ecpg_pkg::ECPG_R_IDLE);
  end

  // ----------------------------------------------------------------
  // Position step from the encoder channels
  // ----------------------------------------------------------------
  logic up;
  logic dn;

  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    if (mode == ecpg_pkg::ECPG_M_TWO_PULSE) begin
      up = rise[`ECPG_IN_A];
      dn = rise[`ECPG_IN_B];
    end else begin
      unique case (dec)
        ecpg_pkg::ECPG_SINGLE_EDGE_DECODE: begin
          up = rise[`ECPG_IN_A] & ~b_lvl;
          dn = fall[`ECPG_IN_A] & ~b_lvl;
        end
        ecpg_pkg::ECPG_DOUBLE_EDGE_DECODE: begin
          up = (rise[`ECPG_IN_A] & ~b_lvl) | (fall[`ECPG_IN_A] & b_lvl);
          dn = (fall[`ECPG_IN_A] & ~b_lvl) | (rise[`ECPG_IN_A] & b_lvl);
        end
        ecpg_pkg::ECPG_QUAD_EDGE_DECODE: begin
          up = (rise[`ECPG_IN_A] & ~b_lvl) | (fall[`ECPG_IN_A] & b_lvl)
             | (rise[`ECPG_IN_B] & a_lvl) | (fall[`ECPG_IN_B] & ~a_lvl);
          dn = (fall[`ECPG_IN_A] & ~b_lvl) | (rise[`ECPG_IN_A] & b_lvl)
             | (fall[`ECPG_IN_B] & a_lvl) | (rise[`ECPG_IN_B] & ~a_lvl);
        end
        default: begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [31:0] stepped;
  logic [31:0] pnext;
  logic        z_hit;
  logic        do_wr;
  logic        sample;

  always_comb begin
    nxt_st  = st_ff;
    stepped = st_ff.count;
    pnext   = st_ff.pcnt + `ECPG_ONE;
    z_hit   = 1'b0;
    do_wr   = 1'b0;
    sample  = 1'b0;

    // Input synchronisers
    nxt_st.sync1 = pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;

    // DMA hand-off drains on ready
    if (st_ff.dma.valid && dma_ready) begin
      nxt_st.dma.valid = 1'b0;
    end

    // Counting functions
    nxt_st.armed = arm_bit;
    if (!arm_bit) begin
      nxt_st.run   = ecpg_pkg::ECPG_R_IDLE;
      nxt_st.pulse = 1'b0;
      nxt_st.pcnt  = `ECPG_RST_WORD;
    end else if (!st_ff.armed) begin
      nxt_st.count = `ECPG_RST_WORD;
      nxt_st.pcnt  = `ECPG_RST_WORD;
      nxt_st.done  = 1'b0;
      nxt_st.ovf   = 1'b0;
      unique case (mode)
        ecpg_pkg::ECPG_M_QUAD,
        ecpg_pkg::ECPG_M_TWO_PULSE:   nxt_st.run = ecpg_pkg::ECPG_R_RUN;
        ecpg_pkg::ECPG_M_SEP_SINGLE,
        ecpg_pkg::ECPG_M_SEP_BUF:     nxt_st.run = ecpg_pkg::ECPG_R_WAIT_AUX;
        ecpg_pkg::ECPG_M_PULSE:       nxt_st.run = ecpg_pkg::ECPG_R_DELAY;
        ecpg_pkg::ECPG_M_PULSE_TRIG,
        ecpg_pkg::ECPG_M_PULSE_RETRIG: nxt_st.run = ecpg_pkg::ECPG_R_WAIT_TRIG;
        default:                      nxt_st.run = ecpg_pkg::ECPG_R_IDLE;
      endcase
    end else begin
      unique case (st_ff.run)
        ecpg_pkg::ECPG_R_IDLE: begin
          nxt_st.run = ecpg_pkg::ECPG_R_IDLE;
        end
        ecpg_pkg::ECPG_R_RUN: begin
          if (up && !dn) begin
            stepped = st_ff.count + `ECPG_ONE;
          end else if (dn && !up) begin
            stepped = st_ff.count - `ECPG_ONE;
          end
          z_hit = (mode == ecpg_pkg::ECPG_M_QUAD) && st_ff.sync2[`ECPG_IN_Z]
                && ({a_lvl, b_lvl} == st_ff.ctrl[`ECPG_CTRL_ZPH_HI:`ECPG_CTRL_ZPH_LO]);
          nxt_st.count = z_hit ? st_ff.reload : stepped;
          sample = st_ff.ctrl[`ECPG_CTRL_SAMP_EN] && gate_edge;
        end
        ecpg_pkg::ECPG_R_WAIT_AUX: begin
          if (aux_edge) begin
            nxt_st.count = `ECPG_RST_WORD;
            nxt_st.run   = ecpg_pkg::ECPG_R_SEP_COUNT;
          end
        end
        ecpg_pkg::ECPG_R_SEP_COUNT: begin
          if (gate_edge) begin
            nxt_st.save = st_ff.count;
            nxt_st.done = 1'b1;
            if (mode == ecpg_pkg::ECPG_M_SEP_BUF) begin
              sample     = 1'b1;
              nxt_st.run = ecpg_pkg::ECPG_R_WAIT_GATE;
            end else begin
              nxt_st.run = ecpg_pkg::ECPG_R_HOLD;
            end
          end else if (src_edge) begin
            nxt_st.count = st_ff.count + `ECPG_ONE;
          end
        end
        ecpg_pkg::ECPG_R_WAIT_GATE: begin
          if (gate_edge) begin
            nxt_st.count = `ECPG_RST_WORD;
            nxt_st.run   = ecpg_pkg::ECPG_R_SEP_COUNT;
          end
        end
        ecpg_pkg::ECPG_R_HOLD: begin
          nxt_st.run = ecpg_pkg::ECPG_R_HOLD;
        end
        ecpg_pkg::ECPG_R_WAIT_TRIG: begin
          if (gate_edge) begin
            nxt_st.pcnt = `ECPG_RST_WORD;
            nxt_st.run  = ecpg_pkg::ECPG_R_DELAY;
          end
        end
        ecpg_pkg::ECPG_R_DELAY: begin
          // Gate is not looked at here or in the high phase
          if (st_ff.pcnt >= st_ff.delay) begin
            nxt_st.pulse = 1'b1;
            nxt_st.pcnt  = `ECPG_RST_WORD;
            nxt_st.run   = ecpg_pkg::ECPG_R_HIGH;
          end else if (src_edge) begin
            nxt_st.pcnt = pnext;
          end
        end
        ecpg_pkg::ECPG_R_HIGH: begin
          if (src_edge && (pnext >= st_ff.width)) begin
            nxt_st.pulse = 1'b0;
            nxt_st.pcnt  = `ECPG_RST_WORD;
            nxt_st.done  = 1'b1;
            nxt_st.run   = (mode == ecpg_pkg::ECPG_M_PULSE_RETRIG)
                         ? ecpg_pkg::ECPG_R_WAIT_TRIG
                         : ecpg_pkg::ECPG_R_HOLD;
          end else if (src_edge) begin
            nxt_st.pcnt = pnext;
          end
        end
        default: begin
          nxt_st.run = ecpg_pkg::ECPG_R_IDLE;
        end
      endcase
    end

    // Sample hand-off; the counter itself is left alone
    if (sample) begin
      nxt_st.dma.data  = (st_ff.run == ecpg_pkg::ECPG_R_RUN) ? nxt_st.count
                                                             : st_ff.count;
      nxt_st.dma.valid = 1'b1;
      if (st_ff.dma.valid && !dma_ready) begin
        nxt_st.ovf = 1'b1;
      end
    end

    // AXI4-Lite write channel
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.awaddr  = s_axi_awaddr;
      nxt_st.aw_got  = 1'b1;
      nxt_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.wdata  = s_axi_wdata;
      nxt_st.wstrb  = s_axi_wstrb;
      nxt_st.w_got  = 1'b1;
      nxt_st.wready = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      do_wr         = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = `ECPG_RESP_OK;
      unique case ({st_ff.awaddr[7:2], 2'h0})
        `ECPG_OFF_CTRL:   nxt_st.ctrl   = merge(st_ff.ctrl, st_ff.wdata, st_ff.wstrb);
        `ECPG_OFF_RELOAD: nxt_st.reload = merge(st_ff.reload, st_ff.wdata, st_ff.wstrb);
        `ECPG_OFF_DELAY:  nxt_st.delay  = merge(st_ff.delay, st_ff.wdata, st_ff.wstrb);
        `ECPG_OFF_WIDTH:  nxt_st.width  = merge(st_ff.width, st_ff.wdata, st_ff.wstrb);
        `ECPG_OFF_COUNT,
        `ECPG_OFF_SAVE,
        `ECPG_OFF_STATUS: nxt_st.bresp  = `ECPG_RESP_OK;
        default:          nxt_st.bresp  = `ECPG_RESP_DEC;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid  = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready  = 1'b1;
    end

    // AXI4-Lite read channel
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid  = 1'b1;
      nxt_st.rresp   = `ECPG_RESP_OK;
      unique case ({s_axi_araddr[7:2], 2'h0})
        `ECPG_OFF_CTRL:   nxt_st.rdata = st_ff.ctrl;
        `ECPG_OFF_RELOAD: nxt_st.rdata = st_ff.reload;
        `ECPG_OFF_DELAY:  nxt_st.rdata = st_ff.delay;
        `ECPG_OFF_WIDTH:  nxt_st.rdata = st_ff.width;
        `ECPG_OFF_COUNT:  nxt_st.rdata = st_ff.count;
        `ECPG_OFF_SAVE:   nxt_st.rdata = st_ff.save;
        `ECPG_OFF_STATUS: nxt_st.rdata = status;
        default: begin
          nxt_st.rdata = `ECPG_RST_WORD;
          nxt_st.rresp = `ECPG_RESP_DEC;
        end
      endcase
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid  = 1'b0;
      nxt_st.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff         <= '0;
      st_ff.run     <= ecpg_pkg::ECPG_R_IDLE;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    s_axi_awready = st_ff.awready;
    s_axi_wready  = st_ff.wready;
    s_axi_bvalid  = st_ff.bvalid;
    s_axi_bresp   = st_ff.bresp;
    s_axi_arready = st_ff.arready;
    s_axi_rvalid  = st_ff.rvalid;
    s_axi_rdata   = st_ff.rdata;
    s_axi_rresp   = st_ff.rresp;
    dma_out       = st_ff.dma;
    pulse_out     = st_ff.pulse;
  end

endmodule

/* src/ecpg_consts.svh */
// Offsets, field positions, reset values and codes of the encoder counter / pulse generator
`ifndef ECPG_CONSTS_SVH
`define ECPG_CONSTS_SVH

// Register byte offsets
`define ECPG_OFF_CTRL    8'h00
`define ECPG_OFF_RELOAD  8'h04
`define ECPG_OFF_DELAY   8'h08
`define ECPG_OFF_WIDTH   8'h0C
`define ECPG_OFF_COUNT   8'h10
`define ECPG_OFF_SAVE    8'h14
`define ECPG_OFF_STATUS  8'h18

// Control register fields
`define ECPG_CTRL_ARM      0
`define ECPG_CTRL_MODE_LO  1
`define ECPG_CTRL_MODE_HI  3
`define ECPG_CTRL_DEC_LO   4
`define ECPG_CTRL_DEC_HI   5
`define ECPG_CTRL_ZPH_LO   6
`define ECPG_CTRL_ZPH_HI   7
`define ECPG_CTRL_SAMP_EN  8
`define ECPG_CTRL_SRC_FALL 9
`define ECPG_CTRL_AUX_FALL 10
`define ECPG_CTRL_GATE_FALL 11

// Status register fields
`define ECPG_ST_ARMED   0
`define ECPG_ST_PULSE   1
`define ECPG_ST_DONE    2
`define ECPG_ST_DVALID  3
`define ECPG_ST_OVF     4
`define ECPG_ST_BUSY    5

// Synchronised input lanes
`define ECPG_IN_A     0
`define ECPG_IN_B     1
`define ECPG_IN_Z     2
`define ECPG_IN_AUX   3
`define ECPG_IN_GATE  4
`define ECPG_IN_SRC   5
`define ECPG_IN_N     6

// Reset values and bus answers
`define ECPG_RST_WORD  32'h0000_0000
`define ECPG_RST_LANES 6'h00
`define ECPG_ONE       32'h0000_0001
`define ECPG_RESP_OK   2'h0
`define ECPG_RESP_DEC  2'h3

`endif

/* src/ecpg_pkg.sv */
// Types shared by the encoder counter / pulse generator
package ecpg_pkg;

  typedef enum logic [2:0] {
    ECPG_M_QUAD,
    ECPG_M_TWO_PULSE,
    ECPG_M_SEP_SINGLE,
    ECPG_M_SEP_BUF,
    ECPG_M_PULSE,
    ECPG_M_PULSE_TRIG,
    ECPG_M_PULSE_RETRIG
  } ecpg_mode_t;

  typedef enum logic [1:0] {
    ECPG_SINGLE_EDGE_DECODE,
    ECPG_DOUBLE_EDGE_DECODE,
    ECPG_QUAD_EDGE_DECODE
  } ecpg_dec_t;

  typedef enum logic [3:0] {
    ECPG_R_IDLE,
    ECPG_R_RUN,
    ECPG_R_WAIT_AUX,
    ECPG_R_SEP_COUNT,
    ECPG_R_WAIT_GATE,
    ECPG_R_HOLD,
    ECPG_R_WAIT_TRIG,
    ECPG_R_DELAY,
    ECPG_R_HIGH
  } ecpg_run_t;

  typedef struct packed {
    logic src;
    logic gate;
    logic aux;
    logic z;
    logic b;
    logic a;
  } ecpg_pins_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } ecpg_dma_t;

  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  prev;
    logic [31:0] ctrl;
    logic [31:0] reload;
    logic [31:0] delay;
    logic [31:0] width;
    logic [31:0] count;
    logic [31:0] save;
    logic [31:0] pcnt;
    ecpg_run_t   run;
    logic        armed;
    logic        done;
    logic        pulse;
    logic        ovf;
    ecpg_dma_t   dma;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ecpg_state_t;

endpackage

/* test/ecpg_enc.sv */
// Encoder and trigger source model driving the counter pins
`timescale 1ns/1ps
module ecpg_enc (
  input  logic                 mclk,
  output ecpg_pkg::ecpg_pins_t pins
);
  // ---
  // Pin drivers
  // ---
  initial pins = '0;

  // Every level stays long enough for the two-stage synchroniser
  task automatic hold;
    repeat (3) @(posedge mclk);
  endtask

  task automatic set(input int lane, input logic v);
    @(posedge mclk);
    pins[lane] <= v;
    hold;
  endtask

  task automatic pulse(input int lane);
    set(lane, 1'b1);
    set(lane, 1'b0);
  endtask

  // One quadrature edge; up means A leads B
  task automatic step(input logic up);
    @(posedge mclk);
    pins.a <= up ? ~pins.b : pins.b;
    pins.b <= up ? pins.a : ~pins.a;
    hold;
  endtask
endmodule

/* test/ecpg_chk_sva.sv */
// Checker for the register bus and sample stream of the counter
`timescale 1ns/1ps
module ecpg_chk (
  input logic                 mclk,
  input logic                 reset_n,
  input logic                 s_axi_awvalid,
  input logic                 s_axi_awready,
  input logic                 s_axi_wvalid,
  input logic                 s_axi_wready,
  input logic [1:0]           s_axi_bresp,
  input logic                 s_axi_bvalid,
  input logic                 s_axi_bready,
  input logic                 s_axi_arvalid,
  input logic                 s_axi_arready,
  input logic [31:0]          s_axi_rdata,
  input logic [1:0]           s_axi_rresp,
  input logic                 s_axi_rvalid,
  input logic                 s_axi_rready,
  input ecpg_pkg::ecpg_pins_t pins,
  input ecpg_pkg::ecpg_dma_t  dma_out,
  input logic                 dma_ready
);
  // ---
  // Properties
  // ---
  logic [4:0] gh;
  logic       gate_moved;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) gh <= '0;
    else gh <= {gh[3:0], pins.gate};
  end
  assign gate_moved = (gh[3:0] != gh[4:1]);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late;
    !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (both_taken |-> resp_late) else $error("write response timing");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_decerr_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("unmapped read data");
  dma_hold_a: assert property (dma_out.valid && !dma_ready |=> dma_out.valid)
    else $error("sample dropped");
  dma_cause_a: assert property ($rose(dma_out.valid) |-> gate_moved)
    else $error("sample without gate edge");
endmodule

bind ecpg_top ecpg_chk i_chk (.mclk(mclk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pins(pins), .dma_out(dma_out), .dma_ready(dma_ready));

/* test/tb.sv */
// Self-checking bench for the encoder counter and pulse generator
`timescale 1ns/1ps
`include "ecpg_consts.svh"
module tb;
  logic        mclk, reset_n, awvalid, wvalid, bready, arvalid, rready, dma_ready;
  logic        awready, wready, bvalid, arready, rvalid, pulse_out;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0]  bresp, rresp, lr, lb;
  logic [4:0]  e;
  logic [3:0]  wstrb;
  logic [31:0] rq[$], dq[$];
  int          n_errors, checked, cyc, seed;
  int          sq[10] = '{`ECPG_IN_SRC, `ECPG_IN_AUX, `ECPG_IN_SRC, `ECPG_IN_SRC, `ECPG_IN_AUX,
                          `ECPG_IN_SRC, `ECPG_IN_GATE, `ECPG_IN_SRC, `ECPG_IN_AUX, `ECPG_IN_GATE};
  int          bq[8] = '{`ECPG_IN_AUX, `ECPG_IN_SRC, `ECPG_IN_SRC, `ECPG_IN_GATE, `ECPG_IN_SRC,
                         `ECPG_IN_GATE, `ECPG_IN_SRC, `ECPG_IN_GATE};
  ecpg_pkg::ecpg_pins_t pins;
  ecpg_pkg::ecpg_dma_t  dma_out;

  ecpg_top i_dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
    .dma_out(dma_out), .dma_ready(dma_ready), .pulse_out(pulse_out));
  ecpg_enc i_enc (.mclk(mclk), .pins(pins));

  // ---
  // Clock, compare and bus tasks
  // ---
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, s, x);
    end
  endtask

  task automatic tally_and_finish;
    n_errors += dq.size() + rq.size();
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    lb = bresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    lr = rresp;
  endtask

  task automatic go(input int m, input int d, input logic [31:0] x);
    wr(`ECPG_OFF_CTRL, 32'h0);
    wr(`ECPG_OFF_CTRL, 32'(1 + (m << 1) + (d << 4)) | x);
  endtask

  always @(posedge mclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk(rdata, rq.size() ? rq.pop_front() : ~rdata);
    if (dma_out.valid === 1'b1 && dma_ready === 1'b1) begin
      chk(dma_out.data, dq.size() ? dq.pop_front() : ~dma_out.data);
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  // ---
  // Scenarios
  // ---
  initial begin
    {n_errors, checked, cyc} = '0;
    seed = 10994;
    {reset_n, awvalid, wvalid, bready, arvalid, rready, dma_ready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    e = 5'b01110;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`ECPG_OFF_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    chk(32'(lr), 32'h3);
    wr(8'h40, 32'h1);
    chk(32'(lb), 32'h3);
    rv = $random(seed);
    wr(`ECPG_OFF_RELOAD, rv);
    rd(`ECPG_OFF_RELOAD, rv);
    wstrb <= 4'h3;
    wr(`ECPG_OFF_RELOAD, ~rv);
    rv = {rv[31:16], ~rv[15:0]};
    wstrb <= 4'hF;
    rd(`ECPG_OFF_RELOAD, rv);
    for (int d = 0; d < 3; d++) begin
      go(0, d, 32'h0);
      repeat (4) i_enc.step(1'b1);
      rd(`ECPG_OFF_COUNT, 32'(1 << d));
      repeat (8) i_enc.step(1'b0);
      rd(`ECPG_OFF_COUNT, -32'(1 << d));
    end
    go(0, 2, 32'h80);
    i_enc.set(`ECPG_IN_Z, 1'b1);
    i_enc.step(1'b1);
    i_enc.set(`ECPG_IN_Z, 1'b0);
    i_enc.step(1'b1);
    rd(`ECPG_OFF_COUNT, rv + 32'h1);
    repeat (2) i_enc.step(1'b1);
    go(1, 0, 32'h0);
    repeat (3) i_enc.pulse(`ECPG_IN_A);
    i_enc.pulse(`ECPG_IN_B);
    rd(`ECPG_OFF_COUNT, 32'h2);
    go(0, 2, 32'h100);
    for (int s = 1; s < 3; s++) begin
      repeat (2) i_enc.step(1'b1);
      dq.push_back(32'(2 * s));
      i_enc.pulse(`ECPG_IN_GATE);
      dma_ready <= 1'b1;
    end
    for (int p = 0; p < 2; p++) begin
      go(2, 0, p ? 32'hE00 : 32'h0);
      foreach (sq[i]) i_enc.pulse(sq[i]);
      rd(`ECPG_OFF_SAVE, 32'h3);
    end
    go(3, 0, 32'h0);
    dq.push_back(32'h2);
    dq.push_back(32'h1);
    foreach (bq[i]) i_enc.pulse(bq[i]);
    rd(`ECPG_OFF_SAVE, 32'h1);
    wr(`ECPG_OFF_DELAY, 32'h2);
    wr(`ECPG_OFF_WIDTH, 32'h3);
    for (int m = 4; m < 7; m++) begin
      go(m, 0, 32'h0);
      if (m > 4) begin
        repeat (2) i_enc.pulse(`ECPG_IN_SRC);
        chk(32'(pulse_out), 32'h0);
      end
      for (int t = 0; t < 2; t++) begin
        if (m > 4) i_enc.pulse(`ECPG_IN_GATE);
        for (int k = 0; k < 5; k++) begin
          i_enc.pulse(`ECPG_IN_SRC);
          if (k == 0 && m > 4) i_enc.pulse(`ECPG_IN_GATE);
          chk(32'(pulse_out), (m == 6 || t == 0) ? 32'(e[k]) : 32'h0);
        end
      end
    end
    for (int r = 0; r < 2; r++) begin
      go(4, 0, 32'h0);
      repeat (2) i_enc.pulse(`ECPG_IN_SRC);
      chk(32'(pulse_out), 32'h1);
      if (r == 0) begin
        wr(`ECPG_OFF_CTRL, 32'h0);
      end else begin
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
      end
      @(posedge mclk);
      chk(32'(pulse_out), 32'h0);
    end
    rd(`ECPG_OFF_CTRL, 32'h0);
    @(posedge mclk);
    tally_and_finish;
  end
endmodule
